// [design/eem_init_mem.sv]
// Written-map memory: one bit per word of the uninitialized-read area.
`timescale 1ns/1ps
`include "eem_params.svh"
module eem_init_mem
   import eem_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wrEn,
   input wire logic [12:0] wrAddr,
   input wire logic wrBit,
   input wire logic [12:0] rdAddr,
   output logic rdBit
);
   logic mem [0:`EEM_INIT_WORDS-1];

   // The array has no reset; the owner sweeps it clear instead.
   always_ff @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrBit;
      end
   end

   // Registered read, one cycle after the address.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rdBit <= 1'b0;
      end
      else
      begin
         rdBit <= mem[rdAddr];
      end
   end
endmodule // eem_init_mem

// [design/eem_monitor.sv]
// Event monitor: detectors, sticky flags and the register port.
`timescale 1ns/1ps
`include "eem_params.svh"
// Operation
// - Flag a protection violation when an access breaks the block's attribute.
// - Instruction fetches are checked like data reads and writes.
// - Attributes: read-write, read-only, write-only, disabled, OS-only.
// - Under OS-only, any access not from OS code is a violation.
// - Any range of the whole address space may be protected.
// - After reset every location is read-write.
// - Sixteen comparison blocks; unmapped ranges stay unprotected.
// - Reading a tracked word never written flags an uninitialized read.
// - Thirty-two blocks within 16 Kbytes, detection enabled per block.
// - Both stack pointers are compared with their ranges every cycle.
// - A pointer outside its range at any moment flags a stack violation.
// - Only pointer values are checked, never stack contents.
// - A section time counter overflow raises a performance overflow.
// - The overflowed section is recorded for the host.
// - Profile time or pass overflow raises one profile overflow event.
// - Profile time accumulator is 40 bits; saturation is the timeout.
// - Profile pass counter is 16 bits; passing 65,535 is the count-out.
// - Trace store overflow past its cycle depth raises one event.
// - A write into another task's stack range flags a task stack violation.
// - Every OS task dispatch raises a dispatch event.
// - Each event is separately enabled for breakpoints and trace points.
module eem_monitor
   import eem_pkg::*;
#(
   parameter int TRACE_DEPTH = `EEM_TRACE_DEPTH
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   input wire logic busFetch,
   input wire logic busRead,
   input wire logic busWrite,
   input wire logic [19:0] busAddr,
   input wire logic busOs,
   input wire logic [15:0] userStackPointer,
   input wire logic [15:0] interruptStackPointer,
   input wire logic [7:0] runningTask,
   input wire logic osDispatch,
   input wire logic perfOverflow,
   input wire logic [3:0] perfSection,
   input wire logic profTick,
   input wire logic profPass,
   input wire logic traceWrite,
   output logic [7:0] eventStatus,
   output logic warnReq,
   output logic breakReq,
   output logic traceReq,
   output logic initBusy
);
   // ************************************************************
   // Declarations
   // ************************************************************
   logic [7:0] status;
   logic [7:0] next_status;
   logic [7:0] warnEn;
   logic [7:0] breakEn;
   logic [7:0] traceEn;
   logic [7:0] ev;
   logic [7:0] clrMask;
   logic [2:0] ctrl;
   logic [3:0] sel;
   logic [15:0] uspLo;
   logic [15:0] uspHi;
   logic [15:0] ispLo;
   logic [15:0] ispHi;
   eem_addr_t initBase;
   logic [31:0] initEn;
   eem_addr_t taskLo [`EEM_TASK_RANGES];
   eem_addr_t taskHi [`EEM_TASK_RANGES];
   logic [7:0] taskId [`EEM_TASK_RANGES];
   logic [`EEM_TASK_RANGES-1:0] taskVld;
   logic [`EEM_TASK_RANGES-1:0] taskBad;
   logic [15:0] perfSect;
   logic [15:0] perfSet;
   logic [39:0] profTime;
   logic [15:0] profCount;
   logic [`EEM_TRACE_CNT_W-1:0] traceCnt;
   logic traceOver;
   logic traceFull;
   logic [`EEM_PROT_BLOCKS-1:0] protViol;
   logic [31:0] rdMux;
   logic [31:0] rdData;
   eem_state_e state;
   logic [12:0] sweep;
   eem_addr_t initOfs;
   logic inArea;
   logic pendRd;
   logic memBit;
   logic memWr;
   logic [12:0] memWrAddr;
   logic stackOut;
   logic stackOutQ;
   logic timeOut;
   logic countOut;
   logic wStatus;
   logic wCtrl;
   logic wSel;
   logic wProtLo;
   logic wProtHi;
   logic wProtAttr;
   logic wTaskLo;
   logic wTaskHi;
   logic wTaskId;
   logic wPerf;
   logic wProf;
   logic wTrace;
   logic initClr;

   // ************************************************************
   // Register write decode
   // ************************************************************
   // One strobe per register; tables go through the selector.
   assign wStatus = regWr && (regAddr == `EEM_OFS_STATUS);
   assign wCtrl = regWr && (regAddr == `EEM_OFS_CTRL);
   assign wSel = regWr && (regAddr == `EEM_OFS_SEL);
   assign wProtLo = regWr && (regAddr == `EEM_OFS_PROT_LO);
   assign wProtHi = regWr && (regAddr == `EEM_OFS_PROT_HI);
   assign wProtAttr = regWr && (regAddr == `EEM_OFS_PROT_ATTR);
   assign wTaskLo = regWr && (regAddr == `EEM_OFS_TASK_LO);
   assign wTaskHi = regWr && (regAddr == `EEM_OFS_TASK_HI);
   assign wTaskId = regWr && (regAddr == `EEM_OFS_TASK_ID);
   assign wPerf = regWr && (regAddr == `EEM_OFS_PERF_SECT);
   assign wProf = regWr && (regAddr == `EEM_OFS_PROF_PASS);
   assign wTrace = regWr && (regAddr == `EEM_OFS_TRACE_CNT);
   assign initClr = wCtrl && regWrData[`EEM_CTRL_INIT_CLR];

   // ************************************************************
   // Configuration registers
   // ************************************************************
   // All zero after reset, so no checker fires before setup.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         warnEn <= `EEM_RST_EV;
         breakEn <= `EEM_RST_EV;
         traceEn <= `EEM_RST_EV;
         ctrl <= 3'h0;
         sel <= 4'h0;
         uspLo <= `EEM_RST_SP;
         uspHi <= `EEM_RST_SP;
         ispLo <= `EEM_RST_SP;
         ispHi <= `EEM_RST_SP;
         initBase <= `EEM_RST_ADDR;
         initEn <= 32'h00000000;
      end
      else if (regWr)
      begin
         unique case (regAddr)
            `EEM_OFS_WARN_EN: warnEn <= regWrData[7:0];
            `EEM_OFS_BREAK_EN: breakEn <= regWrData[7:0];
            `EEM_OFS_TRACE_EN: traceEn <= regWrData[7:0];
            `EEM_OFS_CTRL: ctrl <= {1'b0, regWrData[1:0]};
            `EEM_OFS_SEL: sel <= regWrData[3:0];
            `EEM_OFS_USP_LO: uspLo <= regWrData[15:0];
            `EEM_OFS_USP_HI: uspHi <= regWrData[15:0];
            `EEM_OFS_ISP_LO: ispLo <= regWrData[15:0];
            `EEM_OFS_ISP_HI: ispHi <= regWrData[15:0];
            `EEM_OFS_INIT_BASE: initBase <= regWrData[19:0];
            `EEM_OFS_INIT_EN: initEn <= regWrData;
            default: ;
         endcase
      end
   end

   // Task stack table; the selector's high bits are ignored.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         taskVld <= '0;
         for (int i = 0; i < `EEM_TASK_RANGES; i++)
         begin
            taskLo[i] <= `EEM_RST_ADDR;
            taskHi[i] <= `EEM_RST_ADDR;
            taskId[i] <= 8'h00;
         end
      end
      else
      begin
         if (wTaskLo)
            taskLo[sel[1:0]] <= regWrData[19:0];
         if (wTaskHi)
            taskHi[sel[1:0]] <= regWrData[19:0];
         if (wTaskId)
         begin
            taskId[sel[1:0]] <= regWrData[7:0];
            taskVld[sel[1:0]] <= regWrData[`EEM_TASK_VLD_BIT];
         end
      end
   end

   // ************************************************************
   // Access protection
   // ************************************************************
   // A fixed pool; a range that does not fit stays unguarded.
   for (genvar g = 0; g < `EEM_PROT_BLOCKS; g++)
   begin : gProt
      eem_prot_block uBlk (
         .clk(clk),
         .rst_n(rst_n),
         .wrLo(wProtLo && (sel == 4'(g))),
         .wrHi(wProtHi && (sel == 4'(g))),
         .wrAttr(wProtAttr && (sel == 4'(g))),
         .wrData(regWrData),
         .busAddr(busAddr),
         .busFetch(busFetch),
         .busRead(busRead),
         .busWrite(busWrite),
         .busOs(busOs),
         .violation(protViol[g])
      );
   end

   // ************************************************************
   // Uninitialized read tracking
   // ************************************************************
   // The area is 16 Kbytes from the base; bits 13..9 name one of 32 blocks.
   assign initOfs = busAddr - initBase;
   assign inArea = (initOfs < `EEM_INIT_BYTES);
   // Bus writes during the sweep are lost; clear only when stopped.
   assign memWr = (state == EEM_ST_CLEAR) | (busWrite & inArea);
   assign memWrAddr = (state == EEM_ST_CLEAR) ? sweep : initOfs[13:1];

   eem_init_mem uMem (
      .clk(clk),
      .rst_n(rst_n),
      .wrEn(memWr),
      .wrAddr(memWrAddr),
      .wrBit(state == EEM_ST_RUN),
      .rdAddr(initOfs[13:1]),
      .rdBit(memBit)
   );

   // Reset or a clear command sweeps the whole map to unwritten.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= EEM_ST_CLEAR;
         sweep <= 13'h0000;
      end
      else
      begin
         unique case (state)
            EEM_ST_CLEAR:
            begin
               sweep <= sweep + 13'h0001;
               if (sweep == 13'h1FFF)
                  state <= EEM_ST_RUN;
            end
            EEM_ST_RUN:
            begin
               sweep <= 13'h0000;
               if (initClr)
                  state <= EEM_ST_CLEAR;
            end
         endcase
      end
   end

   // The map bit comes a cycle late, so the read is remembered.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         pendRd <= 1'b0;
      else
         pendRd <= busRead & inArea & initEn[initOfs[13:9]] & (state == EEM_ST_RUN);
   end

   // ************************************************************
   // Stack pointer and task stack checks
   // ************************************************************
   // Only pointer values are compared; stack contents are never looked at.
   assign stackOut = ctrl[`EEM_CTRL_STACK_EN]
      & (~eem_in_range({4'h0, userStackPointer}, {4'h0, uspLo}, {4'h0, uspHi})
      | ~eem_in_range({4'h0, interruptStackPointer}, {4'h0, ispLo}, {4'h0, ispHi}));

   for (genvar t = 0; t < `EEM_TASK_RANGES; t++)
   begin : gTask
      assign taskBad[t] = taskVld[t] & (taskId[t] != runningTask)
         & eem_in_range(busAddr, taskLo[t], taskHi[t]);
   end

   // ************************************************************
   // Profile, performance and trace counters
   // ************************************************************
   // Profile counters saturate, so the host sees the limit.
   assign timeOut = profTick & (profTime == {40{1'b1}});
   assign countOut = profPass & (profCount == 16'hFFFF);
   assign traceFull = (traceCnt == `EEM_TRACE_CNT_W'(TRACE_DEPTH));
   assign perfSet = perfOverflow ? (16'h0001 << perfSection) : 16'h0000;

   always_ff @(posedge clk)
   begin
      if (!rst_n || wProf)
      begin
         profTime <= 40'h0;
         profCount <= 16'h0;
      end
      else
      begin
         if (profTick && !timeOut)
            profTime <= profTime + 40'h1;
         if (profPass && !countOut)
            profCount <= profCount + 16'h1;
      end
   end

   // The trace count stops at the depth; the event fires only once.
   always_ff @(posedge clk)
   begin
      if (!rst_n || wTrace)
      begin
         traceCnt <= '0;
         traceOver <= 1'b0;
      end
      else if (traceWrite)
      begin
         if (!traceFull)
            traceCnt <= traceCnt + `EEM_TRACE_CNT_W'(1);
         else
            traceOver <= 1'b1;
      end
   end

   // ************************************************************
   // Events and sticky flags
   // ************************************************************
   // The stack event marks the step out, not each cycle outside.
   assign ev[`EEM_EV_PROT] = |protViol;
   assign ev[`EEM_EV_INIT] = pendRd & ~memBit;
   assign ev[`EEM_EV_STACK] = stackOut & ~stackOutQ;
   assign ev[`EEM_EV_PERF] = perfOverflow;
   assign ev[`EEM_EV_PROF] = timeOut | countOut;
   assign ev[`EEM_EV_TRACE] = traceWrite & traceFull & ~traceOver;
   assign ev[`EEM_EV_TASK] = busWrite & ctrl[`EEM_CTRL_TASK_EN] & (|taskBad);
   assign ev[`EEM_EV_DISP] = osDispatch;
   assign clrMask = wStatus ? regWrData[7:0] : 8'h00;
   // A new event in the clearing cycle survives the clear.
   assign next_status = (status & ~clrMask) | ev;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         status <= `EEM_RST_EV;
         perfSect <= 16'h0000;
         stackOutQ <= 1'b0;
      end
      else
      begin
         status <= next_status;
         perfSect <= (perfSect & ~(wPerf ? regWrData[15:0] : 16'h0000)) | perfSet;
         stackOutQ <= stackOut;
      end
   end

   // Break and trace requests are pulses; the warning is a level.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         breakReq <= 1'b0;
         traceReq <= 1'b0;
         warnReq <= 1'b0;
      end
      else
      begin
         breakReq <= |(ev & breakEn);
         traceReq <= |(ev & traceEn);
         warnReq <= |(next_status & warnEn);
      end
   end

   // ************************************************************
   // Register read
   // ************************************************************
   // Protection blocks are write-only and read as zero.
   assign rdMux =
      (regAddr == `EEM_OFS_STATUS) ? {24'h0, status} :
      (regAddr == `EEM_OFS_WARN_EN) ? {24'h0, warnEn} :
      (regAddr == `EEM_OFS_BREAK_EN) ? {24'h0, breakEn} :
      (regAddr == `EEM_OFS_TRACE_EN) ? {24'h0, traceEn} :
      (regAddr == `EEM_OFS_CTRL) ? {29'h0, state != EEM_ST_RUN, ctrl[1:0]} :
      (regAddr == `EEM_OFS_SEL) ? {28'h0, sel} :
      (regAddr == `EEM_OFS_USP_LO) ? {16'h0, uspLo} :
      (regAddr == `EEM_OFS_USP_HI) ? {16'h0, uspHi} :
      (regAddr == `EEM_OFS_ISP_LO) ? {16'h0, ispLo} :
      (regAddr == `EEM_OFS_ISP_HI) ? {16'h0, ispHi} :
      (regAddr == `EEM_OFS_INIT_BASE) ? {12'h0, initBase} :
      (regAddr == `EEM_OFS_INIT_EN) ? initEn :
      (regAddr == `EEM_OFS_PERF_SECT) ? {16'h0, perfSect} :
      (regAddr == `EEM_OFS_PROF_TIME_L) ? profTime[31:0] :
      (regAddr == `EEM_OFS_PROF_TIME_H) ? {24'h0, profTime[39:32]} :
      (regAddr == `EEM_OFS_PROF_PASS) ? {16'h0, profCount} :
      (regAddr == `EEM_OFS_TRACE_CNT) ? {traceOver, 8'h00, traceCnt} :
      32'h0;

   // Data stand only the cycle after the strobe.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdData <= 32'h0;
      else
         rdData <= regRd ? rdMux : 32'h0;
   end

   assign regRdData = rdData;
   assign eventStatus = status;
   assign initBusy = (state == EEM_ST_CLEAR);
endmodule // eem_monitor

// [design/eem_params.svh]
// Offsets, field positions, reset values and counts of the event monitor.
`ifndef EEM_PARAMS_SVH
`define EEM_PARAMS_SVH
`define EEM_ADDR_W 20
`define EEM_SP_W 16
`define EEM_EV_W 8
`define EEM_PROT_BLOCKS 16
`define EEM_TASK_RANGES 4
`define EEM_INIT_WORDS 8192
`define EEM_INIT_BYTES 20'h04000
`define EEM_TRACE_DEPTH 4194304
`define EEM_TRACE_CNT_W 23
`define EEM_OFS_STATUS 8'h00
`define EEM_OFS_WARN_EN 8'h04
`define EEM_OFS_BREAK_EN 8'h08
`define EEM_OFS_TRACE_EN 8'h0C
`define EEM_OFS_CTRL 8'h10
`define EEM_OFS_SEL 8'h14
`define EEM_OFS_PROT_LO 8'h18
`define EEM_OFS_PROT_HI 8'h1C
`define EEM_OFS_PROT_ATTR 8'h20
`define EEM_OFS_USP_LO 8'h24
`define EEM_OFS_USP_HI 8'h28
`define EEM_OFS_ISP_LO 8'h2C
`define EEM_OFS_ISP_HI 8'h30
`define EEM_OFS_INIT_BASE 8'h34
`define EEM_OFS_INIT_EN 8'h38
`define EEM_OFS_TASK_LO 8'h3C
`define EEM_OFS_TASK_HI 8'h40
`define EEM_OFS_TASK_ID 8'h44
`define EEM_OFS_PERF_SECT 8'h48
`define EEM_OFS_PROF_TIME_L 8'h4C
`define EEM_OFS_PROF_TIME_H 8'h50
`define EEM_OFS_PROF_PASS 8'h54
`define EEM_OFS_TRACE_CNT 8'h58
`define EEM_EV_PROT 0
`define EEM_EV_INIT 1
`define EEM_EV_STACK 2
`define EEM_EV_PERF 3
`define EEM_EV_PROF 4
`define EEM_EV_TRACE 5
`define EEM_EV_TASK 6
`define EEM_EV_DISP 7
`define EEM_CTRL_STACK_EN 0
`define EEM_CTRL_TASK_EN 1
`define EEM_CTRL_INIT_CLR 2
`define EEM_ATTR_USED_BIT 8
`define EEM_TASK_VLD_BIT 8
`define EEM_RST_EV 8'h00
`define EEM_RST_ADDR 20'h00000
`define EEM_RST_SP 16'h0000
`endif

// [design/eem_pkg.sv]
// Types and the shared range test of the event monitor.
package eem_pkg;
   typedef enum logic [2:0] {EEM_RW = 3'h0, EEM_RO = 3'h1, EEM_WO = 3'h2, EEM_DIS = 3'h3,
      EEM_OS = 3'h4} eem_attr_e;
   typedef enum logic {EEM_ST_CLEAR = 1'b0, EEM_ST_RUN = 1'b1} eem_state_e;
   typedef logic [19:0] eem_addr_t;

   // Inclusive range test shared by protection, stack and task stack checks.
   function automatic logic eem_in_range(input eem_addr_t a, input eem_addr_t lo,
      input eem_addr_t hi);
      return (a >= lo) && (a <= hi);
   endfunction
endpackage

// [design/eem_prot_block.sv]
// One access protection comparison block: range, attribute and violation decode.
`timescale 1ns/1ps
`include "eem_params.svh"
module eem_prot_block
   import eem_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wrLo,
   input wire logic wrHi,
   input wire logic wrAttr,
   input wire logic [31:0] wrData,
   input wire logic [19:0] busAddr,
   input wire logic busFetch,
   input wire logic busRead,
   input wire logic busWrite,
   input wire logic busOs,
   output logic violation
);
   eem_addr_t lo;
   eem_addr_t hi;
   eem_attr_e attr;
   logic used;
   logic hit;
   logic rdAcc;
   logic anyAcc;
   logic bad;

   // An unused block grants read-write, as after reset.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         lo <= `EEM_RST_ADDR;
         hi <= `EEM_RST_ADDR;
         attr <= EEM_RW;
         used <= 1'b0;
      end
      else
      begin
         if (wrLo)
            lo <= wrData[19:0];
         if (wrHi)
            hi <= wrData[19:0];
         if (wrAttr)
         begin
            attr <= eem_attr_e'(wrData[2:0]);
            used <= wrData[`EEM_ATTR_USED_BIT];
         end
      end
   end

   // Fetches count as reads.
   assign rdAcc = busRead | busFetch;
   assign anyAcc = rdAcc | busWrite;
   assign hit = used & eem_in_range(busAddr, lo, hi);
   // Codes above OS-only act as read-write.
   assign bad = ((attr == EEM_RO) & busWrite) | ((attr == EEM_WO) & rdAcc)
      | ((attr == EEM_DIS) & anyAcc) | ((attr == EEM_OS) & anyAcc & ~busOs);
   assign violation = hit & bad;
endmodule // eem_prot_block

// [verif/eem_cpu_model.sv]
// CPU core model: bus accesses, stack pointers and running task.
`timescale 1ns/1ps
module eem_cpu_model
   import eem_pkg::*;
(
   input wire logic clk,
   output logic busFetch,
   output logic busRead,
   output logic busWrite,
   output logic [19:0] busAddr,
   output logic busOs,
   output logic [15:0] userStackPointer,
   output logic [15:0] interruptStackPointer,
   output logic [7:0] runningTask
);
   // Idle bus, pointers inside the stacks used by the bench.
   initial
   begin
      {busFetch, busRead, busWrite, busOs} = 4'h0;
      busAddr = 20'h00000;
      userStackPointer = 16'h1800;
      interruptStackPointer = 16'h2800;
      runningTask = 8'h00;
   end
   // One-cycle access, then the inverse address, so stale values never match.
   task automatic access(input logic [1:0] kind, input logic [19:0] a, input logic os);
      @(posedge clk);
      busFetch <= (kind == 2'h0);
      busRead <= (kind == 2'h1);
      busWrite <= (kind == 2'h2);
      busAddr <= a;
      busOs <= os;
      @(posedge clk);
      {busFetch, busRead, busWrite} <= 3'h0;
      busAddr <= ~a;
      busOs <= ~os;
   endtask
   // Core state change, taken at one edge.
   task automatic core(input logic [15:0] u, input logic [15:0] i, input logic [7:0] t);
      @(posedge clk);
      userStackPointer <= u;
      interruptStackPointer <= i;
      runningTask <= t;
   endtask
endmodule // eem_cpu_model

// [verif/eem_monitor_properties.sv]
// Port-level properties of the event monitor.
`timescale 1ns/1ps
module eem_monitor_chk
   import eem_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic regWr,
   input wire logic osDispatch,
   input wire logic perfOverflow,
   input wire logic traceWrite,
   input wire logic [7:0] eventStatus,
   input wire logic breakReq,
   input wire logic traceReq,
   input wire logic initBusy
);
   // ******************
   // Checks
   // ******************
   localparam int SWEEP = 8193;
   logic [13:0] busyRun;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // A stuck sweep would mute uninitialized reads.
   always_ff @(posedge clk)
      if (!rst_n || !initBusy)
         busyRun <= 14'h0000;
      else
         busyRun <= busyRun + 14'h0001;
   sequence s_dispatch_seen;
      osDispatch ##1 eventStatus[7];
   endsequence
   a_dispatch_flag_set: assert property (osDispatch |-> s_dispatch_seen)
      else $error("dispatch flag not set");
   a_perf_flag_set: assert property (perfOverflow |=> eventStatus[3])
      else $error("performance flag not set");
   a_flag_stays_set: assert property ($past(rst_n) && |($past(eventStatus) & ~eventStatus)
      |-> $past(regWr) && $past(regAddr) == 8'h00)
      else $error("flag dropped without a clear");
   a_trace_flag_cause: assert property ($rose(eventStatus[5]) |-> $past(traceWrite))
      else $error("trace flag without trace write");
   a_break_has_flag: assert property (breakReq |-> eventStatus != 8'h00)
      else $error("break without a flag");
   a_tp_has_flag: assert property (traceReq |-> eventStatus != 8'h00)
      else $error("trace point without a flag");
   a_reset_sweep_runs: assert property ($rose(rst_n) |-> initBusy [*8])
      else $error("sweep not running after reset");
   a_sweep_bounded: assert property (busyRun <= SWEEP)
      else $error("sweep too long");
endmodule // eem_monitor_chk
bind eem_monitor eem_monitor_chk u_chk (.clk(clk), .rst_n(rst_n),
   .regAddr(regAddr), .regWr(regWr), .osDispatch(osDispatch), .perfOverflow(perfOverflow),
   .traceWrite(traceWrite), .eventStatus(eventStatus), .breakReq(breakReq),
   .traceReq(traceReq), .initBusy(initBusy));

// [verif/tb_eem_monitor.sv]
// Self-checking bench of the event monitor.
`timescale 1ns/1ps
module tb_eem_monitor
   import eem_pkg::*;
;
   logic clk, rst_n, regWr, regRd, warnReq, breakReq, traceReq, initBusy;
   logic busFetch, busRead, busWrite, busOs;
   logic [7:0] regAddr, eventStatus, runningTask;
   logic [31:0] regWrData, regRdData, got;
   logic [19:0] busAddr;
   logic [15:0] userStackPointer, interruptStackPointer;
   logic [4:0] evPulse;
   logic [3:0] perfSection;
   int err_total, check_count, cycles, seed, i, k;
   eem_monitor #(.TRACE_DEPTH(8)) dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .busFetch(busFetch), .busRead(busRead), .busWrite(busWrite), .busAddr(busAddr),
      .busOs(busOs), .userStackPointer(userStackPointer),
      .interruptStackPointer(interruptStackPointer), .runningTask(runningTask),
      .osDispatch(evPulse[0]), .perfOverflow(evPulse[1]), .perfSection(perfSection),
      .profTick(evPulse[2]), .profPass(evPulse[3]), .traceWrite(evPulse[4]),
      .eventStatus(eventStatus), .warnReq(warnReq), .breakReq(breakReq),
      .traceReq(traceReq), .initBusy(initBusy));
   eem_cpu_model cpu (.clk(clk), .busFetch(busFetch), .busRead(busRead),
      .busWrite(busWrite), .busAddr(busAddr), .busOs(busOs),
      .userStackPointer(userStackPointer), .interruptStackPointer(interruptStackPointer),
      .runningTask(runningTask));
   // ******************
   // Helpers
   // ******************
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
         err_total++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // Data stand only the cycle after the strobe.
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 got = regRdData;
   endtask
   task automatic pulse(input int b);
      @(posedge clk);
      evPulse[b] <= 1'b1;
      @(posedge clk);
      evPulse[b] <= 1'b0;
   endtask
   // Compare all sticky flags, then clear them.
   task automatic flags(input logic [7:0] e);
      repeat (3) @(posedge clk);
      #1 chk({24'h0, eventStatus}, {24'h0, e});
      wr(8'h00, 32'h000000FF);
   endtask
   // Kind 0 fetch, 1 read, 2 write; a fetch counts as a read.
   function automatic logic expProt(input int a, input int kind, input int os);
      case (a)
         1: return kind == 2;
         2: return kind != 2;
         3: return 1'b1;
         4: return os == 0;
         default: return 1'b0;
      endcase
   endfunction
   task report_and_stop;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         err_total++;
         report_and_stop;
      end
   end
   // ******************
   // Scenarios
   // ******************
   initial
   begin
      seed = 73;
      {rst_n, regWr, regRd, evPulse, perfSection, regAddr} = 0;
      regWrData = 32'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 chk({31'h0, initBusy}, 32'h1);
      for (i = 0; i < 9000 && initBusy !== 1'b0; i++)
         @(posedge clk);
      cpu.access(2'h2, 20'(32'h10000 + ($random(seed) & 32'hFFFF)), 1'b0);
      flags(8'h00);
      wr(8'h14, 32'h0);
      wr(8'h18, 32'h100);
      wr(8'h1C, 32'h1FF);
      for (k = 0; k < 5; k++)
      begin
         wr(8'h20, 32'h100 | k);
         for (i = 0; i < 6; i++)
         begin
            cpu.access(2'(i % 3), 20'(32'h100 + ($random(seed) & 32'hFF)), 1'(i / 3));
            flags({7'h0, expProt(k, i % 3, i / 3)});
         end
      end
      cpu.access(2'h1, 20'h00200, 1'b0);
      flags(8'h00);
      wr(8'h14, 32'h1);
      wr(8'h18, 32'hFFF00);
      wr(8'h1C, 32'hFFFFF);
      wr(8'h20, 32'h103);
      cpu.access(2'h0, 20'hFFFFF, 1'b1);
      flags(8'h01);
      wr(8'h34, 32'h0);
      wr(8'h38, 32'h1);
      cpu.access(2'h2, 20'h00010, 1'b0);
      cpu.access(2'h1, 20'h00010, 1'b0);
      flags(8'h00);
      cpu.access(2'h1, 20'h00020, 1'b0);
      flags(8'h02);
      cpu.access(2'h1, 20'h00300, 1'b0);
      flags(8'h00);
      wr(8'h24, 32'h1000);
      wr(8'h28, 32'h1FFF);
      wr(8'h2C, 32'h2000);
      wr(8'h30, 32'h2FFF);
      wr(8'h10, 32'h1);
      flags(8'h00);
      cpu.core(16'h2000, 16'h2800, 8'h05);
      flags(8'h04);
      cpu.core(16'h1800, 16'h2800, 8'h05);
      cpu.core(16'h1FFF, 16'h1FFF, 8'h05);
      flags(8'h04);
      cpu.core(16'h1800, 16'h2800, 8'h05);
      wr(8'h14, 32'h0);
      wr(8'h3C, 32'h3000);
      wr(8'h40, 32'h30FF);
      wr(8'h44, 32'h105);
      wr(8'h10, 32'h3);
      cpu.access(2'h2, 20'h03010, 1'b0);
      flags(8'h00);
      cpu.core(16'h1800, 16'h2800, 8'h06);
      cpu.access(2'h2, 20'h030FF, 1'b0);
      flags(8'h40);
      perfSection <= 4'h9;
      pulse(1);
      flags(8'h08);
      rd(8'h48);
      chk(got, 32'h200);
      repeat (8) pulse(4);
      flags(8'h00);
      pulse(4);
      flags(8'h20);
      repeat (3) pulse(3);
      rd(8'h54);
      chk(got, 32'h3);
      repeat (2) pulse(2);
      rd(8'h4C);
      chk(got, 32'h2);
      wr(8'h08, 32'h80);
      wr(8'h04, 32'h80);
      pulse(0);
      #1 chk({29'h0, breakReq, traceReq, warnReq}, 32'h5);
      flags(8'h80);
      @(posedge clk);
      #1 chk({31'h0, warnReq}, 32'h0);
      rd(8'hFC);
      chk(got, 32'h0);
      rd(8'h04);
      chk(got, 32'h80);
      report_and_stop;
   end
endmodule // tb_eem_monitor
